/* File: core/sac_pkg.sv */
// Purpose: constants for the first synthesizer control registers
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are byte register numbers

package sac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_CTRL_0 = 8'h38;
    localparam logic [7:0] OFF_CTRL_1 = 8'h39;
    localparam logic [7:0] OFF_FBDIV_HIGH = 8'h3a;
    localparam logic [7:0] OFF_FBDIV_LOW = 8'h3b;
    localparam int POS_PDN = 0;
    localparam int POS_SYNC_EN = 1;
    localparam int POS_PDIV_LO = 2;
    localparam int POS_DBL = 4;
    localparam int POS_CTRL1_RSV = 5;
    localparam logic [2:0] RST_PDIV = 3'h7;
    localparam logic RST_SYNC_EN = 1'b1;
    localparam logic RST_PDN = 1'b0;
    localparam logic RST_DBL = 1'b1;
    localparam logic RST_CTRL1_RSV = 1'b0;
    localparam logic [3:0] RST_CP = 4'h8;
    localparam logic [3:0] RST_FB_HI = 4'h0;
    localparam logic [7:0] RST_FB_LO = 8'h66;
    localparam logic [7:0] MASK_CTRL_0 = 8'h1f;
    localparam logic [7:0] MASK_CTRL_1 = 8'h3f;
    localparam logic [7:0] MASK_FB_HI = 8'h0f;
    localparam logic [7:0] MASK_FB_LO = 8'hff;
    // calibration length in clk cycles, plain default
    localparam logic [7:0] CAL_CYCLES = 8'h40;
    typedef enum logic [1:0] {
        SAC_OFF = 2'b00,
        SAC_CAL = 2'b01,
        SAC_LOCKED = 2'b11
    } sac_state_t;
endpackage

/* File: core/sac_ratio.sv */
// Purpose: registered ratio decode for post and feedback dividers
// Assumes: same clock as register bank
// Notes: one cycle of latency on every ratio

`timescale 1ns/100ps

module sac_ratio
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] pdiv_code,
    input wire logic [11:0] fb_value,
    output logic [3:0] post_ratio,
    output logic [11:0] fb_ratio
);
    logic [3:0] post_d;
    logic [11:0] fb_d;

    always_comb
    begin
        if (pdiv_code < 3'h2)
            post_d = 4'h2;
        else
            post_d = {1'b0, pdiv_code} + 4'h1;
        fb_d = (fb_value == 12'h000) ? 12'h001 : fb_value;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            post_ratio <= 4'h8;
            fb_ratio <= 12'h066;
        end
        else
        begin
            post_ratio <= post_d;
            fb_ratio <= fb_d;
        end
    end
endmodule

/* File: core/sac_regs.sv */
// Purpose: control registers of the first frequency synthesizer
// Assumes: single-cycle strobes, read data valid the cycle after
// Notes: unmapped addresses read zero and ignore writes

`timescale 1ns/100ps

// Functional notes
// - post-divider codes 0,1 give 2, else code+1
// - sync enable resyncs channels on sync event
// - power-down bit gates auto enable after reset
// - power-down set disables, holds calibration reset
// - power-down clear re-enables, restarts calibration
// - doubler enable bit drives primary doubler
// - four-bit pump current code, reset eight
// - twelve-bit feedback ratio, zero means one
// - high divider nibble holds bits eleven..eight
// - low divider byte resets to 0x66
module sac_regs
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [sac_pkg::ADDR_W-1:0] addr,
    input wire logic [sac_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic sync_event,
    output logic [sac_pkg::DATA_W-1:0] rdata,
    output logic [3:0] post_ratio,
    output logic [11:0] fb_ratio,
    output logic [3:0] pump_current_code,
    output logic ref_doubler_enable,
    output logic synth_enable,
    output logic cal_reset,
    output logic cal_done,
    output logic resync_pulse
);
    import sac_pkg::*;

    logic [2:0] post_divider_select_q, post_divider_select_d;
    logic sync_resync_enable_q, sync_resync_enable_d;
    logic synth_a_power_down_q, synth_a_power_down_d;
    logic dbl_q, dbl_d;
    logic rsv5_q, rsv5_d;
    logic [3:0] cp_q, cp_d;
    logic [11:0] feedback_int_divider_q, feedback_int_divider_d;
    logic [7:0] rdata_d;
    sac_state_t state_q, state_d;
    logic [7:0] cal_cnt_q, cal_cnt_d;
    logic sync_m_q, sync_s_q, sync_p_q;
    logic en_d, calrst_d, done_d, resync_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // register bank
    // one write port; every field lands on the write edge
    // reads have no side effects, so back-to-back strobes are harmless
    always_comb
    begin
        post_divider_select_d = post_divider_select_q;
        sync_resync_enable_d = sync_resync_enable_q;
        synth_a_power_down_d = synth_a_power_down_q;
        dbl_d = dbl_q;
        rsv5_d = rsv5_q;
        cp_d = cp_q;
        feedback_int_divider_d = feedback_int_divider_q;
        if (wr_en && hit(addr, OFF_CTRL_0))
        begin
            post_divider_select_d = wdata[POS_PDIV_LO +: 3];
            sync_resync_enable_d = wdata[POS_SYNC_EN];
            synth_a_power_down_d = wdata[POS_PDN];
        end
        if (wr_en && hit(addr, OFF_CTRL_1))
        begin
            dbl_d = wdata[POS_DBL];
            rsv5_d = wdata[POS_CTRL1_RSV];
            cp_d = wdata[3:0];
        end
        if (wr_en && hit(addr, OFF_FBDIV_HIGH))
            feedback_int_divider_d[11:8] = wdata[3:0];
        if (wr_en && hit(addr, OFF_FBDIV_LOW))
            feedback_int_divider_d[7:0] = wdata;
        // unimplemented upper bits are masked off here; spare bit 5 is kept
        rdata_d = 8'h00;
        if (rd_en)
        begin
            if (hit(addr, OFF_CTRL_0))
                rdata_d = {3'h0, post_divider_select_q, sync_resync_enable_q,
                    synth_a_power_down_q} & MASK_CTRL_0;
            else if (hit(addr, OFF_CTRL_1))
                // bit 5 is a stored spare and reads back
                rdata_d = {2'h0, rsv5_q, dbl_q, cp_q} & MASK_CTRL_1;
            else if (hit(addr, OFF_FBDIV_HIGH))
                rdata_d = {4'h0, feedback_int_divider_q[11:8]} & MASK_FB_HI;
            else if (hit(addr, OFF_FBDIV_LOW))
                rdata_d = feedback_int_divider_q[7:0] & MASK_FB_LO;
            else
                rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            post_divider_select_q <= RST_PDIV;
            sync_resync_enable_q <= RST_SYNC_EN;
            synth_a_power_down_q <= RST_PDN;
            dbl_q <= RST_DBL;
            rsv5_q <= RST_CTRL1_RSV;
            cp_q <= RST_CP;
            feedback_int_divider_q <= {RST_FB_HI, RST_FB_LO};
            rdata <= 8'h00;
        end
        else
        begin
            post_divider_select_q <= post_divider_select_d;
            sync_resync_enable_q <= sync_resync_enable_d;
            synth_a_power_down_q <= synth_a_power_down_d;
            dbl_q <= dbl_d;
            rsv5_q <= rsv5_d;
            cp_q <= cp_d;
            feedback_int_divider_q <= feedback_int_divider_d;
            rdata <= rdata_d;
        end
    end

    // synthesizer enable and calibration sequencer
    // calibration length is a plain default; real lock time is analogue
    always_comb
    begin
        state_d = state_q;
        cal_cnt_d = cal_cnt_q;
        case (state_q)
            SAC_OFF:
            begin
                cal_cnt_d = 8'h00;
                if (!synth_a_power_down_q)
                    state_d = SAC_CAL;
            end
            SAC_CAL:
            begin
                // power-down checked first so it beats the final count; a write landing on the lock edge still shows one cycle of lock
                if (synth_a_power_down_q)
                    state_d = SAC_OFF;
                else if (cal_cnt_q == CAL_CYCLES - 8'h01)
                    state_d = SAC_LOCKED;
                else
                    cal_cnt_d = cal_cnt_q + 8'h01;
            end
            SAC_LOCKED:
            begin
                if (synth_a_power_down_q)
                    state_d = SAC_OFF;
            end
            default:
                state_d = SAC_OFF;
        endcase
        en_d = (state_d != SAC_OFF);
        calrst_d = (state_d == SAC_OFF);
        done_d = (state_d == SAC_LOCKED);
        // sync pin is asynchronous, edge taken after two flops
        resync_d = sync_s_q && !sync_p_q && sync_resync_enable_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= SAC_OFF;
            cal_cnt_q <= 8'h00;
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_p_q <= 1'b0;
            synth_enable <= 1'b0;
            cal_reset <= 1'b1;
            cal_done <= 1'b0;
            resync_pulse <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cal_cnt_q <= cal_cnt_d;
            sync_m_q <= sync_event;
            sync_s_q <= sync_m_q;
            sync_p_q <= sync_s_q;
            synth_enable <= en_d;
            cal_reset <= calrst_d;
            cal_done <= done_d;
            resync_pulse <= resync_d;
        end
    end

    // re-registered so every port comes straight from a flop
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pump_current_code <= RST_CP;
            ref_doubler_enable <= RST_DBL;
        end
        else
        begin
            pump_current_code <= cp_q;
            ref_doubler_enable <= dbl_q;
        end
    end

    // ratios trail the write edge by two edges, like the other outputs
    sac_ratio u_ratio (
        .clk(clk),
        .rst_n(rst_n),
        .pdiv_code(post_divider_select_q),
        .fb_value(feedback_int_divider_q),
        .post_ratio(post_ratio),
        .fb_ratio(fb_ratio)
    );
endmodule

/* File: test/sac_props.sv */
// Purpose: port checks for the synthesizer control bank
// Assumes: bound to sac_regs, one clock, sync reset
// Notes: ratios land two edges after the write edge
`timescale 1ns/100ps
module sac_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic sync_event,
    input wire logic [7:0] rdata,
    input wire logic [3:0] post_ratio,
    input wire logic [11:0] fb_ratio,
    input wire logic [3:0] pump_current_code,
    input wire logic ref_doubler_enable,
    input wire logic synth_enable,
    input wire logic cal_reset,
    input wire logic cal_done,
    input wire logic resync_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("rdata not zero outside read");
    a_post_decode: assert property (wr_en && addr == 8'h38 |-> ##2
        post_ratio == (($past(wdata[4:2], 2) < 3'h2) ? 4'h2 : {1'b0, $past(wdata[4:2], 2)} + 4'h1))
        else $error("post ratio wrong");
    a_pump_code: assert property (wr_en && addr == 8'h39 |-> ##2
        pump_current_code == $past(wdata[3:0], 2)) else $error("pump code wrong");
    a_doubler_bit: assert property (wr_en && addr == 8'h39 |-> ##2
        ref_doubler_enable == $past(wdata[4], 2)) else $error("doubler wrong");
    a_fb_low_byte: assert property (wr_en && addr == 8'h3b && wdata != 8'h00 |-> ##2
        fb_ratio[7:0] == $past(wdata, 2)) else $error("fb low byte wrong");
    a_fb_never_zero: assert property (fb_ratio != 12'h000)
        else $error("fb ratio zero");
    a_pdn_disables: assert property (wr_en && addr == 8'h38 && wdata[0] |-> ##2
        !synth_enable && cal_reset && !cal_done) else $error("power-down ignored");
    a_cal_excl: assert property (synth_enable != cal_reset)
        else $error("enable and cal reset agree");
    a_done_after_cal: assert property ($rose(cal_done) |-> $past(synth_enable, 8))
        else $error("cal done too early");
    a_resync_single: assert property (resync_pulse |=> !resync_pulse)
        else $error("resync pulse too long");
    a_resync_source: assert property (resync_pulse |-> $past(sync_event, 3))
        else $error("resync without sync edge");
    c_resync: cover property (resync_pulse);
    c_cal_done: cover property ($rose(cal_done));
    c_pdn_write: cover property (wr_en && addr == 8'h38 && wdata[0]);
endmodule
bind sac_regs sac_props sac_props_inst (.*);

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the synthesizer control bank
// Assumes: plain strobe register port, 40 MHz clock
// Notes: seed fixed so runs repeat
`timescale 1ns/100ps
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, v); end end
module tb_top;
    import sac_pkg::*;
    logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, sync_event = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, d;
    logic [3:0] post_ratio, pump_current_code;
    logic [11:0] fb_ratio, v;
    logic ref_doubler_enable, synth_enable, cal_reset, cal_done, resync_pulse;
    int errors = 0, n_compared = 0, k, pulses;
    always #12.5 clk = ~clk;
    sac_regs sac_regs_inst (.*);
    function automatic logic [3:0] post_of(logic [2:0] c);
        return c < 3'h2 ? 4'h2 : {1'b0, c} + 4'h1;
    endfunction
    task automatic wr(logic [7:0] a, logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        `CHK("rdata", e, rdata)
    endtask
    // outputs settle two edges after the write edge
    task automatic hold2;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic sync_try(int e);
        pulses = 0;
        @(posedge clk);
        sync_event <= 1'b1;
        repeat (10)
        begin
            @(posedge clk);
            #1;
            pulses += (resync_pulse === 1'b1);
        end
        @(posedge clk);
        sync_event <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("resync count", e, pulses)
    endtask
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(40653));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("synth_enable", 1'b1, synth_enable)
        `CHK("fb_ratio", 12'h066, fb_ratio)
        rd(8'h38, 8'h1e);
        rd(8'h39, 8'h18);
        rd(8'h3a, 8'h00);
        rd(8'h3b, 8'h66);
        rd(8'h37, 8'h00);
        for (k = 0; k < 8; k++)
        begin
            wr(8'h38, {3'h0, k[2:0], 2'b10});
            hold2();
            `CHK("post_ratio", post_of(k[2:0]), post_ratio)
        end
        for (k = 1; k < 9; k++)
        begin
            wr(8'h39, {3'h0, k[0], k[3:0]});
            hold2();
            `CHK("pump", k[3:0], pump_current_code)
            `CHK("doubler", k[0], ref_doubler_enable)
        end
        for (k = 0; k < 6; k++)
        begin
            v = k == 0 ? 12'h000 : k == 1 ? 12'hfff : 12'($urandom);
            wr(8'h3a, {4'($urandom), v[11:8]});
            wr(8'h3b, v[7:0]);
            hold2();
            `CHK("fb_ratio", v == 12'h000 ? 12'h001 : v, fb_ratio)
            rd(8'h3a, {4'h0, v[11:8]});
        end
        // bits 7:6 of 0x39 and unmapped places must not keep written bits; spare bit 5 reads back
        for (k = 0; k < 20; k++)
        begin
            d = 8'($urandom);
            wr(8'h39, d);
            rd(8'h39, d & 8'h3f);
            wr(8'h3c, d);
            rd(8'h3c, 8'h00);
        end
        wr(8'h38, 8'h1f);
        hold2();
        `CHK("synth_enable", 1'b0, synth_enable)
        `CHK("cal_reset", 1'b1, cal_reset)
        wr(8'h38, 8'h1e);
        hold2();
        `CHK("synth_enable", 1'b1, synth_enable)
        `CHK("cal_done", 1'b0, cal_done)
        repeat (70) @(posedge clk);
        #1;
        `CHK("cal_done", 1'b1, cal_done)
        sync_try(1);
        wr(8'h38, 8'h1c);
        sync_try(0);
        wrap_up();
    end
endmodule
